// ---- design/speech_core_regs.vh ----
// Constants for the speech core transfer/branch execution block
`ifndef SPEECH_CORE_REGS_VH
`define SPEECH_CORE_REGS_VH
// Bus register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_PC 12'h008
`define REG_ACC 12'h00c
`define REG_BREG 12'h010
`define REG_INDEX 12'h014
`define REG_TIMER 12'h018
`define REG_PITCH 12'h01c
`define REG_EXCIT 12'h020
`define REG_DAC 12'h024
`define ROM_WIN_BIT 10
`define RAM_WIN_BIT 11
// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_INTEGER_BIT 1
// Status register fields
`define STAT_RUN_BIT 0
`define STAT_FLAG_BIT 1
`define STAT_MODE_LSB 8
// Mode register fields
`define MODE_LPC_BIT 0
`define MODE_PCM_BIT 1
// Opcodes
`define OP_POWER_DOWN 8'h3f
`define OP_SUB_MEM 8'h29
`define OP_ACC_TO_B 8'h1a
`define OP_STORE_IDX 8'h16
`define OP_STORE_DIR 8'h6a
`define OP_STORE_POST_INC 8'h20
`define OP_ACC_TO_MODE 8'h1d
`define OP_ACC_TO_PRESC 8'h19
`define OP_ACC_TO_SYNTH 8'h1c
`define OP_ACC_TO_TIMER 8'h1e
`define OP_ACC_TO_INDEX 8'h21
`define OP_STORE_B_IDX 8'h2a
`define OP_LOAD_CONST 8'h6e
// Reset values
`define RST_PC 14'h0000
`define RST_MODE 8'h00
`define RST_PRESC 8'h00
`endif

// ---- design/speech_cpu_transfer_branch_exec.v ----
// Execution core for branch, power-down, subtract and transfer instructions, Wishbone slave
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "speech_core_regs.vh"

// Functional notes
// RL1 - With flag set, short page branch replaces low seven PC bits; else falls through.
// RL2 - Branch keeps page bits of the already incremented PC (7F lands in page 80).
// RL3 - Untaken branch at xx7F or xxFF wraps to xx00 or xx80.
// RL4 - Power-down stops the core and floats all I/O ports.
// RL5 - Restart only on init pin rising edge; RAM kept, registers undefined. The code also restarts on a control register GO write.
// RL6 - Subtract RAM at X from A; RAM byte sign-extended in sign-extend mode.
// RL7 - Flag set on borrow out of bit 8 of low byte compare, else cleared.
// RL8 - Branch and all transfers here leave the status flag at 1.
// RL9 - Transfers to B and X copy A, A unchanged.
// RL10 - Stores write only the low eight bits of the source register.
// RL11 - Store-and-increment writes A at X then increments X.
// RL12 - Mode transfer copies low eight bits of A to mode register.
// RL13 - Prescale transfer loads prescaler; timer ticks every prescale plus one clocks.
// RL14 - Timer transfer copies low eight bits of A to the timer.
// RL15 - Synth transfer routes A by LPC/PCM bits: pitch, DAC, pitch, excitation.
// RL16 - PCM-only synth transfer loads the twelve-bit DAC register.
// RL17 - With neither mode on, synth transfer still loads pitch.
// RL18 - Program keeps pitch LSB/MSB zero, voiced pitch at least 0042.
// RL19 - Unvoiced frames still load pitch between 0042 and 03FE.
// RL20 - Load constant puts operand in A, sign-extended in sign-extend mode.
// RL21 - Two-byte instructions take operand after opcode and skip past it.
module speech_cpu_transfer_branch_exec #(
    parameter ROM_AW = 8,
    parameter RAM_AW = 7
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [11:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire init_pin_i,
    output reg powered_down_o,
    output reg io_oe_n_o
);
    localparam S_OFF = 2'b01;
    localparam S_RUN = 2'b10;

    reg [7:0] rom [0:(1<<ROM_AW)-1];
    reg [7:0] ram [0:(1<<RAM_AW)-1];

    reg [1:0] state_q;
    reg [13:0] pc_q;
    reg [13:0] acc_q;
    reg [13:0] b_q;
    reg [7:0] x_q;
    reg status_flag_q;
    reg integer_mode_q;
    reg [7:0] mode_q;
    reg [7:0] presc_q;
    reg [7:0] presc_cnt_q;
    reg [7:0] timer_q;
    reg [13:0] pitch_q;
    reg [13:0] excit_q;
    reg [11:0] dac_q;
    reg init_s1_q;
    reg init_s2_q;
    reg init_s3_q;
    reg init_lvl_q;
    reg go_q;

    // Widen a byte to the 14-bit A width by the current arithmetic mode
    function [13:0] widen;
        input [7:0] v;
        input int_mode;
        begin
            widen = int_mode ? {6'h00, v} : {{6{v[7]}}, v};
        end
    endfunction

    // Next PC of a short page branch; a taken branch takes its page from the incremented PC
    function [13:0] branch_next;
        input [13:0] pc;
        input [6:0] target;
        input taken;
        reg [13:0] inc;
        begin
            inc = pc + 14'h0001;
            if (taken) begin
                branch_next = {inc[13:7], target};
            end else begin
                // Low bits wrap inside the page: no carry into the page bits
                branch_next = {pc[13:7], pc[6:0] + 7'h01};
            end
        end
    endfunction

    wire [7:0] opcode = rom[pc_q[ROM_AW-1:0]];
    wire [13:0] pc_inc = pc_q + 14'h0001;
    wire [13:0] pc_inc2 = pc_q + 14'h0002;
    wire [7:0] imm_byte = rom[pc_inc[ROM_AW-1:0]];
    wire [7:0] mem_at_x = ram[x_q[RAM_AW-1:0]];
    wire [13:0] sub_res = acc_q - widen(mem_at_x, integer_mode_q);
    wire running = state_q[1];
    wire init_rise = init_s2_q & init_s3_q & ~init_lvl_q;
    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire bus_wr = bus_req & we_i & sel_i[0];
    wire rom_hit = adr_i[`ROM_WIN_BIT] & ~adr_i[`RAM_WIN_BIT];
    wire ram_hit = adr_i[`RAM_WIN_BIT] & ~adr_i[`ROM_WIN_BIT];
    wire presc_tick = (presc_cnt_q == presc_q);
    wire rom_wr = bus_wr & rom_hit;
    wire ram_wr = bus_wr & ram_hit;

    // Core store port: which byte this instruction writes, and with what
    reg core_wr_d;
    reg [RAM_AW-1:0] core_wr_addr_d;
    reg [7:0] core_wr_data_d;
    always @* begin
        core_wr_d = 1'b0;
        core_wr_addr_d = x_q[RAM_AW-1:0];
        core_wr_data_d = acc_q[7:0]; // RL10
        if (running) begin
            case (opcode)
                `OP_STORE_IDX, `OP_STORE_POST_INC: begin
                    core_wr_d = 1'b1; // RL10 RL11
                end
                `OP_STORE_DIR: begin
                    core_wr_d = 1'b1;
                    core_wr_addr_d = imm_byte[RAM_AW-1:0]; // RL21
                end
                `OP_STORE_B_IDX: begin
                    core_wr_d = 1'b1;
                    core_wr_data_d = b_q[7:0]; // RL10
                end
                default: begin
                end
            endcase
        end
    end

    // Init pin sampling: a change counts once stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            init_s1_q <= 1'b0;
            init_s2_q <= 1'b0;
            init_s3_q <= 1'b0;
            init_lvl_q <= 1'b0;
        end else begin
            init_s1_q <= init_pin_i;
            init_s2_q <= init_s1_q;
            init_s3_q <= init_s2_q;
            if (init_s2_q == init_s3_q) begin
                init_lvl_q <= init_s3_q;
            end
        end
    end

    // Memories: bus loads program and data; core stores land after bus writes
    always @(posedge clk_i) begin
        if (rom_wr) begin
            rom[adr_i[ROM_AW+1:2]] <= dat_i[7:0];
        end
        if (ram_wr) begin
            ram[adr_i[RAM_AW+1:2]] <= dat_i[7:0];
        end
        // Core store is last so it wins over a bus write to the same byte
        if (core_wr_d) begin
            ram[core_wr_addr_d] <= core_wr_data_d; // RL10 RL11 RL21
        end
    end

    // Timer and its prescaler; timer counts down on each prescaler wrap
    // A load restarts the counter so the first tick is a full period
    always @(posedge clk_i) begin
        if (rst_i) begin
            presc_cnt_q <= 8'h00;
            timer_q <= 8'h00;
        end else if (running && opcode == `OP_ACC_TO_TIMER) begin
            timer_q <= acc_q[7:0]; // RL14
            presc_cnt_q <= 8'h00;
        end else if (running && opcode == `OP_ACC_TO_PRESC) begin
            presc_cnt_q <= 8'h00;
        end else if (running) begin
            presc_cnt_q <= presc_tick ? 8'h00 : presc_cnt_q + 8'h01; // RL13
            if (presc_tick) begin
                timer_q <= timer_q - 8'h01; // RL13
            end
        end
    end

    // Instruction execution
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_OFF;
            pc_q <= `RST_PC;
            acc_q <= 14'h0000;
            b_q <= 14'h0000;
            x_q <= 8'h00;
            status_flag_q <= 1'b1;
            mode_q <= `RST_MODE;
            presc_q <= `RST_PRESC;
            pitch_q <= 14'h0000;
            excit_q <= 14'h0000;
            dac_q <= 12'h000;
            powered_down_o <= 1'b1;
            io_oe_n_o <= 1'b1;
        end else begin
            case (state_q)
                S_OFF: begin
                    // Only a restart leaves power-down; PC reloads RST_PC, other registers keep stale values
                    if (init_rise || go_q) begin // RL5
                        state_q <= S_RUN;
                        pc_q <= `RST_PC;
                        powered_down_o <= 1'b0;
                        io_oe_n_o <= 1'b0;
                    end
                end
                S_RUN: begin
                    pc_q <= pc_inc;
                    if (opcode[7]) begin
                        pc_q <= branch_next(pc_q, opcode[6:0], status_flag_q); // RL1 RL2 RL3
                        status_flag_q <= 1'b1; // RL8
                    end else begin
                        case (opcode)
                            `OP_POWER_DOWN: begin
                                state_q <= S_OFF; // RL4
                                powered_down_o <= 1'b1; // RL4
                                io_oe_n_o <= 1'b1; // RL4
                            end
                            `OP_SUB_MEM: begin
                                acc_q <= sub_res; // RL6
                                status_flag_q <= (acc_q[7:0] < mem_at_x); // RL7
                            end
                            `OP_ACC_TO_B: begin
                                b_q <= acc_q; // RL9
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_ACC_TO_INDEX: begin
                                x_q <= acc_q[7:0]; // RL9
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_STORE_IDX, `OP_STORE_B_IDX: begin
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_STORE_POST_INC: begin
                                x_q <= x_q + 8'h01; // RL11
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_STORE_DIR: begin
                                pc_q <= pc_inc2; // RL21
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_ACC_TO_MODE: begin
                                mode_q <= acc_q[7:0]; // RL12
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_ACC_TO_PRESC: begin
                                presc_q <= acc_q[7:0]; // RL13
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_ACC_TO_TIMER: begin
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_ACC_TO_SYNTH: begin
                                // Pitch value limits are left to the program
                                case ({mode_q[`MODE_LPC_BIT], mode_q[`MODE_PCM_BIT]})
                                    2'b00: begin
                                        pitch_q <= acc_q; // RL17
                                    end
                                    2'b01: begin
                                        dac_q <= acc_q[11:0]; // RL15 RL16
                                    end
                                    2'b10: begin
                                        pitch_q <= acc_q; // RL15
                                    end
                                    2'b11: begin
                                        excit_q <= acc_q; // RL15
                                    end
                                    default: begin
                                        pitch_q <= acc_q; // RL15
                                    end
                                endcase
                                status_flag_q <= 1'b1; // RL8
                            end
                            `OP_LOAD_CONST: begin
                                acc_q <= widen(imm_byte, integer_mode_q); // RL20
                                pc_q <= pc_inc2; // RL21
                                status_flag_q <= 1'b1; // RL8
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                default: begin
                    state_q <= S_OFF;
                end
            endcase
        end
    end

    // Wishbone slave: one-cycle registered answer, unmapped reads give zero
    // Masking with ack keeps a held strobe from being taken twice in a row
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            go_q <= 1'b0;
            integer_mode_q <= 1'b0;
        end else begin
            ack_o <= bus_req;
            go_q <= 1'b0;
            if (bus_wr && adr_i == `REG_CTRL) begin
                go_q <= dat_i[`CTRL_GO_BIT];
                integer_mode_q <= dat_i[`CTRL_INTEGER_BIT];
            end
            dat_o <= 32'h00000000;
            if (bus_req && !we_i) begin
                if (rom_hit) begin
                    dat_o <= {24'h000000, rom[adr_i[ROM_AW+1:2]]};
                end else if (ram_hit) begin
                    dat_o <= {24'h000000, ram[adr_i[RAM_AW+1:2]]};
                end else begin
                    case (adr_i)
                        `REG_CTRL: dat_o <= {30'h00000000, integer_mode_q, 1'b0};
                        `REG_STATUS: dat_o <= {16'h0000, mode_q, 6'h00,
                                               status_flag_q, running};
                        `REG_PC: dat_o <= {18'h00000, pc_q};
                        `REG_ACC: dat_o <= {18'h00000, acc_q};
                        `REG_BREG: dat_o <= {18'h00000, b_q};
                        `REG_INDEX: dat_o <= {24'h000000, x_q};
                        `REG_TIMER: dat_o <= {16'h0000, presc_q, timer_q};
                        `REG_PITCH: dat_o <= {18'h00000, pitch_q};
                        `REG_EXCIT: dat_o <= {18'h00000, excit_q};
                        `REG_DAC: dat_o <= {20'h00000, dac_q};
                        default: dat_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end
endmodule // speech_cpu_transfer_branch_exec
`default_nettype wire

// ---- sim/exec_checker_props.sv ----
// Port-level checker for the speech core execution block
`timescale 1ns/1ps
`default_nettype none
module exec_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic init_pin_i,
    input wire logic powered_down_o,
    input wire logic io_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] low_q;
    logic [2:0] wr_q;
    // The pin is synchronised over several flops, so quiet means seven low cycles
    always @(posedge clk_i) begin
        if (rst_i || init_pin_i) begin
            low_q <= 3'd0;
        end else if (low_q != 3'd7) begin
            low_q <= low_q + 3'd1;
        end
    end
    always @(posedge clk_i) begin
        wr_q <= {wr_q[1:0], cyc_i & stb_i & we_i};
    end
    property p_off_float;
        powered_down_o |-> io_oe_n_o;
    endproperty
    a_off_float: assert property (p_off_float) else $error("ports driven while off");
    property p_run_drive;
        !powered_down_o && $past(!powered_down_o) |-> !io_oe_n_o;
    endproperty
    a_run_drive: assert property (p_run_drive) else $error("ports float while running");
    property p_stay_off;
        powered_down_o && low_q == 3'd7 && wr_q == 3'b000 |=> powered_down_o;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("core woke without cause");
    property p_init_wake;
        $rose(init_pin_i) && powered_down_o |-> ##[1:8] !powered_down_o;
    endproperty
    a_init_wake: assert property (p_init_wake) else $error("init edge did not restart");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
    property p_ack_cause;
        ack_o |-> $past(cyc_i && stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle;
        !ack_o |-> dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
endmodule // exec_checker
bind speech_cpu_transfer_branch_exec exec_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .dat_o(dat_o), .ack_o(ack_o), .init_pin_i(init_pin_i),
    .powered_down_o(powered_down_o), .io_oe_n_o(io_oe_n_o)
);
`default_nettype wire

// ---- sim/speech_prog_rom.sv ----
// Program image that the bench loads into the core's internal ROM
`timescale 1ns/1ps
`default_nettype none
module speech_prog_rom (
    input wire logic [7:0] addr_i,
    output logic [7:0] byte_o
);
    // Operand bytes sit right after their opcode; pitch 0044 is even and in range
    localparam logic [0:40][7:0] LO = {
        160'h6e851a6e1021162a298c6e996a20201a6e021d6e,
        168'h8b1c6e031d6e421c6e001d6e441c6eff196e3c1eff};
    always_comb begin
        byte_o = 8'h00;
        if (addr_i <= 8'h28) begin
            byte_o = LO[addr_i];
        end
        case (addr_i)
            8'h7f: byte_o = 8'h85;
            8'h80: byte_o = 8'h6e;
            8'h81: byte_o = 8'hf5;
            8'h82: byte_o = 8'h1d;
            8'h83: byte_o = 8'h3f;
            8'h85: byte_o = 8'h6e;
            8'h87: byte_o = 8'h29;
            8'hff: byte_o = 8'hff;
            default: ;
        endcase
    end
endmodule // speech_prog_rom
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the speech core execution block
`timescale 1ns/1ps
`default_nettype none
`include "speech_core_regs.vh"
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, init_pin_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0;
    logic [7:0] rom_a = 8'h00;
    logic [31:0] rd;
    wire [31:0] dat_o;
    wire ack_o, powered_down_o, io_oe_n_o;
    wire [7:0] rom_d;
    int err_count = 0;
    int checks_done = 0;
    always #5 clk_i = ~clk_i;
    speech_cpu_transfer_branch_exec dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .init_pin_i(init_pin_i), .powered_down_o(powered_down_o), .io_oe_n_o(io_oe_n_o));
    speech_prog_rom prog (.addr_i(rom_a), .byte_o(rom_d));
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        chk("ack", 32'h1, {31'h0, ack_o});
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic run_chk(input logic [13:0] a_e, input logic [13:0] b_e, input logic [11:0] d_e);
        int n;
        repeat (8) @(posedge clk_i);
        chk("running", 32'h0, {31'h0, powered_down_o});
        chk("io driven", 32'h0, {31'h0, io_oe_n_o});
        n = 0;
        do begin @(posedge clk_i); n++; end while (powered_down_o !== 1'b1 && n < 2000);
        chk("io float", 32'h1, {31'h0, io_oe_n_o});
        rd_chk("acc", `REG_ACC, {18'h0, a_e});
        rd_chk("breg", `REG_BREG, {18'h0, b_e});
        rd_chk("index", `REG_INDEX, 32'h11);
        rd_chk("timer", `REG_TIMER, 32'hff3c);
        rd_chk("pitch", `REG_PITCH, 32'h44);
        rd_chk("excit", `REG_EXCIT, 32'h42);
        rd_chk("dac", `REG_DAC, {20'h0, d_e});
        rd_chk("ram20", 12'h880, 32'h8b);
        rd_chk("ram10", 12'h840, 32'h8b);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("mode", 32'hf500, rd & 32'hff01);
        chk("flag", 32'h2, rd & 32'h2);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 256; i++) begin
            rom_a = i[7:0];
            #1;
            bus(1'b1, {2'b01, i[7:0], 2'b00}, {24'h0, rom_d});
        end
        // RAM is not reset, so the byte the late subtract reads is seeded here
        bus(1'b1, 12'h844, 32'h0);
        rd_chk("pc", `REG_PC, 32'h0);
        rd_chk("unmapped", 12'h030, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("status reset", 32'h2, rd & 32'hff03);
        bus(1'b1, `REG_CTRL, 32'h1);
        run_chk(14'h3ff5, 14'h008b, 12'hf8b);
        bus(1'b1, `REG_CTRL, 32'h2);
        repeat (20) @(posedge clk_i);
        chk("stay off", 32'h1, {31'h0, powered_down_o});
        init_pin_i <= 1'b1;
        run_chk(14'h00f5, 14'h3f8b, 12'h08b);
        init_pin_i <= 1'b0;
        complete_run;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        err_count++;
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
